// *** testbench.sv ***
// Self-checking bench for the coexistence block with a WLAN-side model.
// Assumes the block answers APB with no wait states and a 100 MHz pclk.
`timescale 1ns/1ns
module testbench
  import wcx_pkg::*;
;
  // ------------------------------------------------------------
  // Stimulus signals.
  // ------------------------------------------------------------
  logic        pclk = 1'b0;
  logic        presetn = 1'b0;
  logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata;
  logic        pready, pslverr;
  logic        bb_frame_start = 1'b0, bb_frame_end = 1'b0, bb_rx_active = 1'b0;
  logic        bb_tx_active = 1'b0, bb_pkt_end = 1'b0, bb_pa_request = 1'b0;
  logic        bb_hop_in_band = 1'b0, bb_acl_high_prio = 1'b0;
  logic [2:0]  bb_traffic_kind = 3'h0, bb_acl_handle = 3'h0;
  logic        want_inh = 1'b0, act_high = 1'b1;
  logic        inhibit_pin, busy, prio, hint, pa_en;
  int          failures = 0;
  int          tests_run = 0;

  // The clock toggles every half period of 5 ns.
  always #5 pclk = ~pclk;

  wcx_coex_top dut (.pclk(pclk), .presetn(presetn), .clk_en(1'b1), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .bb_frame_start(bb_frame_start), .bb_frame_end(bb_frame_end),
    .bb_rx_active(bb_rx_active), .bb_tx_active(bb_tx_active),
    .bb_pkt_end(bb_pkt_end), .bb_pa_request(bb_pa_request),
    .bb_hop_in_band(bb_hop_in_band), .bb_traffic_kind(bb_traffic_kind),
    .bb_acl_high_prio(bb_acl_high_prio), .bb_acl_handle(bb_acl_handle),
    .wlan_tx_inhibit_in(inhibit_pin), .radio_busy_out(busy),
    .coex_priority_out(prio), .channel_hint_out(hint), .pa_enable_out(pa_en));

  wcx_wlan_model wlan (.pclk(pclk), .want_inhibit(want_inh), .active_high(act_high),
    .wlan_tx_inhibit_in(inhibit_pin));

  // ------------------------------------------------------------
  // Shared tasks.
  // ------------------------------------------------------------
  // Compares one word and counts it.
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      failures++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // Compares one bit and counts it.
  task automatic chkb(input logic got, input logic exp);
    chk({31'h0, got}, {31'h0, exp});
  endtask

  // Waits n edges, then lets that edge's updates land.
  task automatic look(input int n);
    repeat (n) @(posedge pclk);
    #1;
  endtask

  // One APB transfer; the request holds until pready is seen at an edge.
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                     output logic [31:0] rd, output logic err);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do
    begin
      @(posedge pclk);
    end
    while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // Reads a register and checks data and error response.
  task automatic rdc(input logic [11:0] a, input logic [31:0] exp, input logic e);
    logic [31:0] rd;
    logic        err;
    apb(1'b0, a, 32'h0000_0000, rd, err);
    chk(rd, exp);
    chkb(err, e);
  endtask

  // Writes a register.
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] rd;
    logic        err;
    apb(1'b1, a, d, rd, err);
  endtask

  // ------------------------------------------------------------
  // Scenarios.
  // ------------------------------------------------------------
  // Runs one frame: pulse window, then direction, then frame end.
  task automatic frame(input logic [2:0] k, input logic hp, input logic [2:0] h,
                       input logic ep);
    @(posedge pclk);
    bb_frame_start <= 1'b1;
    bb_traffic_kind <= k;
    bb_acl_high_prio <= hp;
    bb_acl_handle <= h;
    @(posedge pclk);
    bb_frame_start <= 1'b0;
    #1;
    chkb(busy, 1'b1);
    chkb(prio, ep);
    look(1990);
    chkb(prio, ep);
    look(20);
    chkb(prio, 1'b0);
    @(posedge pclk);
    bb_tx_active <= 1'b1;
    look(3);
    chkb(prio, 1'b1);
    @(posedge pclk);
    bb_tx_active <= 1'b0;
    bb_frame_end <= 1'b1;
    @(posedge pclk);
    bb_frame_end <= 1'b0;
    look(2);
    chkb(busy, 1'b0);
    chkb(prio, 1'b0);
  endtask

  // Before muxing, busy and priority stay low and the inhibit pin is ignored.
  task automatic unmuxed();
    @(posedge pclk);
    bb_rx_active <= 1'b1;
    bb_pa_request <= 1'b1;
    want_inh <= 1'b1;
    look(6);
    chkb(busy, 1'b0);
    chkb(prio, 1'b0);
    chkb(pa_en, 1'b1);
    @(posedge pclk);
    bb_rx_active <= 1'b0;
    want_inh <= 1'b0;
  endtask

  // With the band gate on, receive raises busy only on in-band hops.
  task automatic band();
    wr(ADDR_CTRL, 32'h0000_0007);
    @(posedge pclk);
    bb_rx_active <= 1'b1;
    look(3);
    chkb(busy, 1'b0);
    @(posedge pclk);
    bb_hop_in_band <= 1'b1;
    look(2);
    chkb(busy, 1'b1);
    @(posedge pclk);
    bb_rx_active <= 1'b0;
    wr(ADDR_CTRL, 32'h0000_0003);
  endtask

  // Drives the inhibit request and checks the amplifier after it settles.
  task automatic inh(input logic want, input int n, input logic exp);
    @(posedge pclk);
    want_inh <= want;
    look(n);
    chkb(pa_en, exp);
  endtask

  // Inhibit in both polarities, then inhibit in mid-packet.
  task automatic amp();
    inh(1'b1, 6, 1'b0);
    rdc(ADDR_STAT, 32'h0000_0028, 1'b0);
    inh(1'b0, 6, 1'b1);
    act_high <= 1'b0;
    wr(ADDR_CTRL, 32'h0000_0001);
    inh(1'b0, 6, 1'b1);
    inh(1'b1, 6, 1'b0);
    inh(1'b0, 6, 1'b1);
    act_high <= 1'b1;
    wr(ADDR_CTRL, 32'h0000_0003);
    look(6);
    @(posedge pclk);
    bb_tx_active <= 1'b1;
    inh(1'b1, 10, 1'b1);
    @(posedge pclk);
    bb_pkt_end <= 1'b1;
    bb_tx_active <= 1'b0;
    @(posedge pclk);
    bb_pkt_end <= 1'b0;
    look(2);
    chkb(pa_en, 1'b0);
    inh(1'b0, 6, 1'b1);
  endtask

  // Prints the verdict and ends the run.
  task automatic print_verdict();
    if (failures == 0 && tests_run > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  // Cuts a hang short well beyond the expected run of about 16k cycles.
  initial
  begin
    repeat (40000) @(posedge pclk);
    failures++;
    print_verdict();
  end

  // Main sequence.
  initial
  begin
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    rdc(ADDR_CTRL, {29'h0, CTRL_RST}, 1'b0);
    rdc(ADDR_ACLPRI, {24'h0, ACLPRI_RST}, 1'b0);
    rdc(12'h010, 32'h0000_0000, 1'b1);
    unmuxed();
    wr(ADDR_CTRL, 32'h0000_0003);
    wr(ADDR_ACLPRI, 32'h0000_0020);
    rdc(ADDR_CTRL, 32'h0000_0003, 1'b0);
    rdc(ADDR_ACLPRI, 32'h0000_0020, 1'b0);
    rdc(ADDR_STAT, 32'h0000_0004, 1'b0);
    for (int k = 0; k < 6; k++)
      frame(3'(k), 1'b0, 3'h4, k != 0 && k != 2);
    frame(KIND_ACL, 1'b1, 3'h4, 1'b1);
    frame(KIND_ACL, 1'b0, 3'h5, 1'b1);
    band();
    amp();
    chkb(hint, 1'b0);
    print_verdict();
  end
endmodule // testbench

// *** wcx_apb_regs.sv ***
// APB slave holding the coexistence control and priority-mask registers.
// Assumes an APB master on pclk; answers in the first access cycle.
`timescale 1ns/1ns
module wcx_apb_regs
  import wcx_pkg::*;
(
  input  wire logic               pclk,
  input  wire logic               presetn,
  input  wire logic               clk_en,
  input  wire logic               psel,
  input  wire logic               penable,
  input  wire logic               pwrite,
  input  wire logic [11:0]        paddr,
  input  wire logic [31:0]        pwdata,
  input  wire logic [STAT_W-1:0]  status,
  output logic      [31:0]        prdata,
  output logic                    pready,
  output logic                    pslverr,
  output logic      [CTRL_W-1:0]  ctrl_r,
  output logic      [NUM_HDL-1:0] aclpri_r
);

  // ------------------------------------------------------------
  // Decode.
  // ------------------------------------------------------------
  logic hit;    // Address matches a register.
  logic wr_go;  // Write completes at this edge.

  // Decode the full byte address; anything else is an error.
  always_comb
  begin
    hit = (paddr == ADDR_CTRL) || (paddr == ADDR_ACLPRI) || (paddr == ADDR_STAT);
  end

  assign wr_go = psel && penable && pready && pwrite && hit;

  // Ready and read data are prepared in the setup cycle.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end
    else if (clk_en)
    begin
      pready  <= psel && !penable;
      pslverr <= psel && !penable && !hit;
      prdata  <= 32'h0000_0000;
      if (psel && !penable && !pwrite)
      begin
        case (paddr)
          ADDR_CTRL:   prdata <= 32'(ctrl_r);
          ADDR_ACLPRI: prdata <= 32'(aclpri_r);
          ADDR_STAT:   prdata <= 32'(status);
          default:     prdata <= 32'h0000_0000;
        endcase
      end
    end
  end

  // Writes take effect at the edge that samples pready.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ctrl_r   <= CTRL_RST;
      aclpri_r <= ACLPRI_RST;
    end
    else if (clk_en && wr_go)
    begin
      if (paddr == ADDR_CTRL)
        ctrl_r <= pwdata[CTRL_W-1:0];
      if (paddr == ADDR_ACLPRI)
        aclpri_r <= pwdata[NUM_HDL-1:0];
    end
  end

endmodule // wcx_apb_regs

// *** wcx_coex_top.sv ***
// Top of the WLAN coexistence signalling block in the radio baseband.
// Assumes baseband status inputs on pclk and an inhibit pin from outside.
//
// How it works
// - Asserted inhibit keeps the amplifier disabled.
// - Inhibit mid-packet: finish packet, then amplifier off.
// - Inhibit polarity selectable by software.
// - Twenty microsecond priority pulse after busy rises.
// - Voice, flagged ACL, page, inquiry, sniff are priority.
// - Each ACL handle can be marked priority.
// - After the pulse, priority shows direction.
// - Busy asserts on frame start and receive.
// - Optional busy restriction to in-band hops.
// - Channel hint output is reserved, held low.
// - Pins must be muxed before coexistence use.
//
// The register addresses and the APB slave port are this design's own decisions.
`timescale 1ns/1ns
module wcx_coex_top
  import wcx_pkg::*;
(
  input  wire logic                pclk,
  input  wire logic                presetn,
  input  wire logic                clk_en,
  input  wire logic                psel,
  input  wire logic                penable,
  input  wire logic                pwrite,
  input  wire logic [11:0]         paddr,
  input  wire logic [31:0]         pwdata,
  output logic      [31:0]         prdata,
  output logic                     pready,
  output logic                     pslverr,
  input  wire logic                bb_frame_start,
  input  wire logic                bb_frame_end,
  input  wire logic                bb_rx_active,
  input  wire logic                bb_tx_active,
  input  wire logic                bb_pkt_end,
  input  wire logic                bb_pa_request,
  input  wire logic                bb_hop_in_band,
  input  wire logic [2:0]          bb_traffic_kind,
  input  wire logic                bb_acl_high_prio,
  input  wire logic [HANDLE_W-1:0] bb_acl_handle,
  input  wire logic                wlan_tx_inhibit_in,
  output logic                     radio_busy_out,
  output logic                     coex_priority_out,
  output logic                     channel_hint_out,
  output logic                     pa_enable_out
);

  // ------------------------------------------------------------
  // Registers and configuration.
  // ------------------------------------------------------------
  logic [CTRL_W-1:0]  ctrl_r;     // Control register.
  logic [NUM_HDL-1:0] aclpri_r;   // Priority mask, one bit per handle.
  logic [STAT_W-1:0]  status;     // Live state shown to software.
  logic               coex_en;    // Pins carry the coexistence function.
  logic               inh_pol;    // Inhibit is active high when set.
  logic               band_only;  // Busy only on in-band hops.
  wcx_pa_st_t         pa_st_r;    // Amplifier control state.
  wcx_pa_st_t         pa_st_nxt;  // Next amplifier state.
  logic               inhibit_act;  // Inhibit after polarity and pin mux.

  assign coex_en   = ctrl_r[CTRL_MUX_BIT];
  assign inh_pol   = ctrl_r[CTRL_POL_BIT];
  assign band_only = ctrl_r[CTRL_BAND_BIT];

  // Status packs outputs, inhibit and amplifier state for software.
  assign status = {pa_st_r, inhibit_act, pa_enable_out, coex_priority_out, radio_busy_out};

  // The register slave owns the bus handshake.
  wcx_apb_regs u_regs (
    .pclk     (pclk),
    .presetn  (presetn),
    .clk_en   (clk_en),
    .psel     (psel),
    .penable  (penable),
    .pwrite   (pwrite),
    .paddr    (paddr),
    .pwdata   (pwdata),
    .status   (status),
    .prdata   (prdata),
    .pready   (pready),
    .pslverr  (pslverr),
    .ctrl_r   (ctrl_r),
    .aclpri_r (aclpri_r)
  );

  // ------------------------------------------------------------
  // Inhibit pin synchroniser.
  // ------------------------------------------------------------
  logic inh_meta_r;   // First stage, read only by the second.
  logic inh_sync_r;   // Second stage, safe to use.

  // Two flops because the inhibit pin comes from another chip.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      inh_meta_r <= 1'b0;
      inh_sync_r <= 1'b0;
    end
    else if (clk_en)
    begin
      inh_meta_r <= wlan_tx_inhibit_in;
      inh_sync_r <= inh_meta_r;
    end
  end

  // Polarity folds in here; an unmuxed pin is ignored entirely.
  assign inhibit_act = coex_en && (inh_sync_r == inh_pol);

  // ------------------------------------------------------------
  // Amplifier control.
  // ------------------------------------------------------------

  // Next state: a packet on the air drains before the amplifier stops.
  always_comb
  begin
    pa_st_nxt = pa_st_r;
    case (pa_st_r)
      WCX_PA_RUN:
      begin
        if (inhibit_act && bb_tx_active && !bb_pkt_end)
          pa_st_nxt = WCX_PA_DRAIN;
        else if (inhibit_act)
          pa_st_nxt = WCX_PA_OFF;
      end
      WCX_PA_DRAIN:
      begin
        if (!inhibit_act)
          pa_st_nxt = WCX_PA_RUN;
        else if (bb_pkt_end || !bb_tx_active)
          pa_st_nxt = WCX_PA_OFF;
      end
      WCX_PA_OFF:
      begin
        if (!inhibit_act)
          pa_st_nxt = WCX_PA_RUN;
      end
      default:
        pa_st_nxt = WCX_PA_OFF;
    endcase
  end

  // State register.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      pa_st_r <= WCX_PA_RUN;
    else if (clk_en)
      pa_st_r <= pa_st_nxt;
  end

  // The amplifier follows the baseband only outside the off state.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      pa_enable_out <= 1'b0;
    else if (clk_en)
      pa_enable_out <= bb_pa_request && (pa_st_nxt != WCX_PA_OFF);
  end

  // ------------------------------------------------------------
  // Radio busy.
  // ------------------------------------------------------------
  logic frame_r;           // Inside a frame.
  logic radio_busy_level;  // Busy before the output flop.
  logic busy_rise;         // Busy rises this cycle.

  // Start wins over end when both arrive together.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      frame_r <= 1'b0;
    else if (clk_en)
    begin
      if (bb_frame_start)
        frame_r <= 1'b1;
      else if (bb_frame_end)
        frame_r <= 1'b0;
    end
  end

  // Busy on the starting cycle already, so the partner sees it early.
  always_comb
  begin
    radio_busy_level = (frame_r || bb_frame_start || bb_rx_active)
                       && (!band_only || bb_hop_in_band)
                       && coex_en;
  end

  // Output flop.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      radio_busy_out <= 1'b0;
    else if (clk_en)
      radio_busy_out <= radio_busy_level;
  end

  assign busy_rise = radio_busy_level && !radio_busy_out;

  // ------------------------------------------------------------
  // Priority and direction.
  // ------------------------------------------------------------
  logic prio_now;  // Current traffic counts as priority.
  logic win_r;     // Pulse window running.
  logic hi_r;      // Level held during the window.

  // Classify traffic; ACL qualifies by its own flag or its handle mask.
  always_comb
  begin
    case (bb_traffic_kind)
      KIND_VOICE, KIND_PAGE, KIND_INQUIRY, KIND_SNIFF:
        prio_now = 1'b1;
      KIND_ACL:
        prio_now = bb_acl_high_prio || aclpri_r[bb_acl_handle];
      default:
        prio_now = 1'b0;
    endcase
  end

  // Window timer, restarted on every busy rise.
  wcx_prio_timer u_timer (
    .pclk    (pclk),
    .presetn (presetn),
    .clk_en  (clk_en),
    .start   (busy_rise),
    .abort   (!radio_busy_level),
    .hi_in   (prio_now),
    .win_r   (win_r),
    .hi_r    (hi_r)
  );

  // Pulse first, then transmit direction for the rest of the activity.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      coex_priority_out <= 1'b0;
    else if (clk_en)
    begin
      if (!radio_busy_level)
        coex_priority_out <= 1'b0;
      else if (busy_rise)
        coex_priority_out <= prio_now;
      else if (win_r)
        coex_priority_out <= hi_r;
      else
        coex_priority_out <= bb_tx_active;
    end
  end

  // The hint pin has no function yet and stays low.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      channel_hint_out <= 1'b0;
    else if (clk_en)
      channel_hint_out <= 1'b0;
  end

  // ------------------------------------------------------------
  // Checks.
  // ------------------------------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn || !clk_en);

  // A priority busy rise, then busy held; a drop of busy ends the window early,
  // so the pulse is only judged while busy has stayed up behind it.
  sequence s_rise_prio;
    busy_rise && prio_now && clk_en;
  endsequence
  sequence s_busy_hold;
    radio_busy_level[*8];
  endsequence

  chk_inhibit_pa_off: assert property (
    (pa_st_r == WCX_PA_OFF) && inhibit_act |=> !pa_enable_out)
    else $error("Amplifier enabled under inhibit.");

  chk_pkt_drain: assert property (
    (pa_st_r == WCX_PA_RUN) && inhibit_act && bb_tx_active && !bb_pkt_end
    && bb_pa_request |=> pa_enable_out)
    else $error("Amplifier cut mid-packet.");

  chk_inh_polarity: assert property (
    coex_en && (inh_sync_r != inh_pol) |-> !inhibit_act)
    else $error("Inhibit seen at wrong polarity.");

  chk_prio_pulse: assert property (
    s_rise_prio ##1 s_busy_hold |=> coex_priority_out && $past(coex_priority_out, 8))
    else $error("Priority pulse too short.");

  chk_prio_class: assert property (
    busy_rise && (bb_traffic_kind == KIND_VOICE) |=> coex_priority_out)
    else $error("Voice traffic gave no priority pulse.");

  chk_acl_handle: assert property (
    busy_rise && (bb_traffic_kind == KIND_ACL) && aclpri_r[bb_acl_handle]
    |=> coex_priority_out)
    else $error("Marked handle gave no priority pulse.");

  chk_dir_after: assert property (
    radio_busy_level && !busy_rise && !win_r |=> coex_priority_out == $past(bb_tx_active))
    else $error("Direction not shown after the pulse.");

  chk_busy_frame: assert property (
    coex_en && bb_frame_start && !band_only |=> radio_busy_out)
    else $error("Busy missing at frame start.");

  chk_band_gate: assert property (
    band_only && !bb_hop_in_band |=> !radio_busy_out)
    else $error("Busy raised on an out-of-band hop.");

  chk_hint_low: assert property (
    ##1 !channel_hint_out)
    else $error("Reserved hint pin driven high.");

  chk_unmuxed_idle: assert property (
    !coex_en |-> !inhibit_act ##1 (!radio_busy_out && !coex_priority_out))
    else $error("Outputs active while pins are unmuxed.");

endmodule // wcx_coex_top

// *** wcx_pkg.sv ***
// Shared constants for the WLAN coexistence signalling block.
// Assumes a 100 MHz pclk and an APB register port with 32-bit data.
package wcx_pkg;

  // ------------------------------------------------------------
  // Timing.
  // ------------------------------------------------------------
  localparam int CLK_MHZ      = 100;  // Clock rate in MHz.
  localparam int PRIO_US      = 20;   // Priority pulse length in microseconds.
  localparam int CNT_W        = 12;   // Width of the pulse timer.
  localparam logic [CNT_W-1:0] PRIO_CYC = CNT_W'(PRIO_US * CLK_MHZ);

  // ------------------------------------------------------------
  // Register map, byte addresses.
  // ------------------------------------------------------------
  localparam logic [11:0] ADDR_CTRL   = 12'h000;  // Control bits.
  localparam logic [11:0] ADDR_ACLPRI = 12'h004;  // Per-handle priority mask.
  localparam logic [11:0] ADDR_STAT   = 12'h008;  // Live status, read only.

  // Control fields.
  localparam int CTRL_MUX_BIT  = 0;  // Pins carry the coexistence function.
  localparam int CTRL_POL_BIT  = 1;  // Inhibit polarity, 1 means active high.
  localparam int CTRL_BAND_BIT = 2;  // Busy only on in-band hops.
  localparam int CTRL_W        = 3;  // Implemented control bits.
  localparam logic [CTRL_W-1:0] CTRL_RST = 3'h2;

  // ACL handle mask.
  localparam int HANDLE_W = 3;
  localparam int NUM_HDL  = 8;
  localparam logic [NUM_HDL-1:0] ACLPRI_RST = 8'h00;

  // Status width.
  localparam int STAT_W = 6;

  // Traffic kinds reported by the baseband.
  localparam logic [2:0] KIND_BULK    = 3'h0;
  localparam logic [2:0] KIND_VOICE   = 3'h1;
  localparam logic [2:0] KIND_ACL     = 3'h2;
  localparam logic [2:0] KIND_PAGE    = 3'h3;
  localparam logic [2:0] KIND_INQUIRY = 3'h4;
  localparam logic [2:0] KIND_SNIFF   = 3'h5;

  // Amplifier control states.
  typedef enum logic [1:0] {WCX_PA_RUN, WCX_PA_DRAIN, WCX_PA_OFF} wcx_pa_st_t;

endpackage : wcx_pkg

// *** wcx_prio_timer.sv ***
// Window timer for the priority pulse that follows a busy rise.
// Assumes start and abort come from logic on the same clock.
`timescale 1ns/1ns
module wcx_prio_timer
  import wcx_pkg::*;
(
  input  wire logic pclk,
  input  wire logic presetn,
  input  wire logic clk_en,
  input  wire logic start,
  input  wire logic abort,
  input  wire logic hi_in,
  output logic      win_r,
  output logic      hi_r
);

  logic [CNT_W-1:0] cnt_r;  // Cycles left in the window.

  // The start cycle itself is the first pulse cycle, so count two less.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      cnt_r <= '0;
      win_r <= 1'b0;
      hi_r  <= 1'b0;
    end
    else if (clk_en)
    begin
      if (abort)
      begin
        win_r <= 1'b0;
        hi_r  <= 1'b0;
      end
      else if (start)
      begin
        cnt_r <= PRIO_CYC - CNT_W'(2);
        win_r <= 1'b1;
        hi_r  <= hi_in;
      end
      else if (win_r)
      begin
        cnt_r <= cnt_r - CNT_W'(1);
        if (cnt_r == '0)
          win_r <= 1'b0;
      end
    end
  end

endmodule // wcx_prio_timer

// *** wcx_wlan_model.sv ***
// Model of the WLAN controller that owns the transmit inhibit pin.
// Assumes it shares pclk with the block and is told the pin polarity.
`timescale 1ns/1ns
module wcx_wlan_model
  import wcx_pkg::*;
(
  input  wire logic pclk,
  input  wire logic want_inhibit,
  input  wire logic active_high,
  output logic      wlan_tx_inhibit_in
);
  // The pin starts released, so nothing is inhibited before it is asked for.
  initial wlan_tx_inhibit_in = 1'b0;

  // The pin moves just after a clock edge to the level that the block's
  // configured polarity reads as asserted or released.
  always @(posedge pclk)
  begin
    wlan_tx_inhibit_in <= want_inhibit ? active_high : ~active_high;
  end
endmodule // wcx_wlan_model
